/* mdc_top.sv */
// Motion detect control: control register, thresholds, detectors and
// the linked or loop sequencing between them.
// Assumes register accesses and samples come from logic on ref_clk_i.
//
// Contract
// - Sequencing field bit 4 clear: detectors run independently, status held until read.
// - Default sequencing keeps automatic sleep entry disabled.
// - Field 01: one detector armed at a time; host read acknowledges.
// - Field 11: alternate detectors; events acknowledged internally.
// - Linked or loop applies only with both enables set.
// - Bit 3 selects referenced (1) or absolute (0) inactivity.
// - Bit 2 enables the inactivity detector.
// - Bit 1 selects referenced (1) or absolute (0) activity.
// - Bit 0 enables the activity detector.
// - Control register resets to zero; upper bits read back as written.
// - Activity: any axis magnitude above threshold for the run count.
// - Inactivity: all axes below threshold for the 16-bit run count.
// - A run count of zero acts as one.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"

module mdc_top (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_n_i,
  input  wire mdc_pkg::mdc_reg_req_type reg_req_i,
  output logic                  [7:0]  reg_rdata_o,
  output logic                         reg_rvalid_o,
  input  wire mdc_pkg::mdc_sample_type reg_sample_i,
  output logic                         motion_event_o,
  output logic                         still_event_o,
  output logic                         motion_status_o,
  output logic                         still_status_o,
  output logic                         awake_o,
  output logic                         motion_armed_o,
  output logic                         still_armed_o,
  output logic                         autosleep_permit_o
);
  import mdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  ctrl;
  logic [7:0]  mthr_l;
  logic [2:0]  mthr_h;
  logic [7:0]  mcnt;
  logic [7:0]  sthr_l;
  logic [2:0]  sthr_h;
  logic [7:0]  scnt_l;
  logic [7:0]  scnt_h;
  logic [7:0]  next_ctrl;
  logic [7:0]  next_mthr_l;
  logic [2:0]  next_mthr_h;
  logic [7:0]  next_mcnt;
  logic [7:0]  next_sthr_l;
  logic [2:0]  next_sthr_h;
  logic [7:0]  next_scnt_l;
  logic [7:0]  next_scnt_h;
  logic [7:0]  next_rdata;
  logic        next_rvalid;

  // Sequencing state
  mdc_arm_type arm_state;
  mdc_arm_type next_arm_state;
  logic        motion_stat;
  logic        still_stat;
  logic        awake;
  logic        next_motion_stat;
  logic        next_still_stat;
  logic        next_awake;

  // Detector wiring
  logic        both_en;
  logic        linked;
  logic        loop;
  logic        motion_armed;
  logic        still_armed;
  logic        status_read;
  logic [10:0] mthr;
  logic [10:0] sthr;
  logic [2:0]  m_ok;
  logic [2:0]  s_ok;
  logic [12:0] m_mag [3];
  logic [12:0] s_mag [3];
  logic [11:0] axis  [3];
  logic        m_hit;
  logic        s_hit;
  logic        m_evt;
  logic        s_evt;

  ////////////////////////////////////////////////////////////////////////
  // Register writes; unmapped writes are dropped
  always_comb begin
    next_ctrl   = ctrl;
    next_mthr_l = mthr_l;
    next_mthr_h = mthr_h;
    next_mcnt   = mcnt;
    next_sthr_l = sthr_l;
    next_sthr_h = sthr_h;
    next_scnt_l = scnt_l;
    next_scnt_h = scnt_h;
    if (reg_req_i.wr) begin
      if (reg_req_i.addr == `MDC_ADDR_CTRL) begin
        next_ctrl = reg_req_i.wdata;
      end else if (reg_req_i.addr == `MDC_ADDR_MTHR_L) begin
        next_mthr_l = reg_req_i.wdata;
      end else if (reg_req_i.addr == `MDC_ADDR_MTHR_H) begin
        next_mthr_h = reg_req_i.wdata[2:0];
      end else if (reg_req_i.addr == `MDC_ADDR_MCNT) begin
        next_mcnt = reg_req_i.wdata;
      end else if (reg_req_i.addr == `MDC_ADDR_STHR_L) begin
        next_sthr_l = reg_req_i.wdata;
      end else if (reg_req_i.addr == `MDC_ADDR_STHR_H) begin
        next_sthr_h = reg_req_i.wdata[2:0];
      end else if (reg_req_i.addr == `MDC_ADDR_SCNT_L) begin
        next_scnt_l = reg_req_i.wdata;
      end else if (reg_req_i.addr == `MDC_ADDR_SCNT_H) begin
        next_scnt_h = reg_req_i.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads; answer lands one cycle after the strobe
  always_comb begin
    next_rvalid = reg_req_i.rd;
    next_rdata  = reg_rdata_o;
    if (reg_req_i.rd) begin
      if (reg_req_i.addr == `MDC_ADDR_CTRL) begin
        next_rdata = ctrl;
      end else if (reg_req_i.addr == `MDC_ADDR_STATUS) begin
        next_rdata = 8'h00;
        next_rdata[`MDC_STAT_MOTION] = motion_stat;
        next_rdata[`MDC_STAT_STILL]  = still_stat;
        next_rdata[`MDC_STAT_AWAKE]  = awake;
      end else if (reg_req_i.addr == `MDC_ADDR_MTHR_L) begin
        next_rdata = mthr_l;
      end else if (reg_req_i.addr == `MDC_ADDR_MTHR_H) begin
        next_rdata = {5'b0_0000, mthr_h};
      end else if (reg_req_i.addr == `MDC_ADDR_MCNT) begin
        next_rdata = mcnt;
      end else if (reg_req_i.addr == `MDC_ADDR_STHR_L) begin
        next_rdata = sthr_l;
      end else if (reg_req_i.addr == `MDC_ADDR_STHR_H) begin
        next_rdata = {5'b0_0000, sthr_h};
      end else if (reg_req_i.addr == `MDC_ADDR_SCNT_L) begin
        next_rdata = scnt_l;
      end else if (reg_req_i.addr == `MDC_ADDR_SCNT_H) begin
        next_rdata = scnt_h;
      end else begin
        next_rdata = 8'h00; // Unmapped reads as zero
      end
    end
  end

  // Register file flops
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ctrl         <= `MDC_CTRL_RESET;
      mthr_l       <= `MDC_REG_RESET;
      mthr_h       <= 3'h0;
      mcnt         <= `MDC_REG_RESET;
      sthr_l       <= `MDC_REG_RESET;
      sthr_h       <= 3'h0;
      scnt_l       <= `MDC_REG_RESET;
      scnt_h       <= `MDC_REG_RESET;
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      ctrl         <= next_ctrl;
      mthr_l       <= next_mthr_l;
      mthr_h       <= next_mthr_h;
      mcnt         <= next_mcnt;
      sthr_l       <= next_sthr_l;
      sthr_h       <= next_sthr_h;
      scnt_l       <= next_scnt_l;
      scnt_h       <= next_scnt_h;
      reg_rdata_o  <= next_rdata;
      reg_rvalid_o <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode; field value 10 falls back to default like 00
  always_comb begin
    both_en = ctrl[`MDC_CTRL_MOTION_EN] && ctrl[`MDC_CTRL_STILL_EN];
    linked  = both_en && ctrl[`MDC_CTRL_SEQ_LO];
    loop    = linked && ctrl[`MDC_CTRL_SEQ_HI];
    motion_armed = ctrl[`MDC_CTRL_MOTION_EN] &&
                   (!linked || arm_state == MDC_ARM_MOTION);
    still_armed  = ctrl[`MDC_CTRL_STILL_EN] &&
                   (!linked || arm_state == MDC_ARM_STILL);
    status_read  = reg_req_i.rd && reg_req_i.addr == `MDC_ADDR_STATUS;
    mthr = {mthr_h, mthr_l};
    sthr = {sthr_h, sthr_l};
    axis[0] = reg_sample_i.x;
    axis[1] = reg_sample_i.y;
    axis[2] = reg_sample_i.z;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-axis magnitude, separate references for each detector
  for (genvar a = 0; a < 3; a++) begin : g_axis
    mdc_axis_cmp u_motion_cmp (
      .ref_clk_i    (ref_clk_i),
      .reset_n_i    (reset_n_i),
      .armed_i      (motion_armed),
      .referenced_i (ctrl[`MDC_CTRL_MOTION_REF]),
      .valid_i      (reg_sample_i.valid),
      .sample_i     (axis[a]),
      .ok_o         (m_ok[a]),
      .mag_o        (m_mag[a])
    );
    mdc_axis_cmp u_still_cmp (
      .ref_clk_i    (ref_clk_i),
      .reset_n_i    (reset_n_i),
      .armed_i      (still_armed),
      .referenced_i (ctrl[`MDC_CTRL_STILL_REF]),
      .valid_i      (reg_sample_i.valid),
      .sample_i     (axis[a]),
      .ok_o         (s_ok[a]),
      .mag_o        (s_mag[a])
    );
  end

  // Any axis above for activity, every axis below for inactivity
  always_comb begin
    m_hit = 1'b0;
    s_hit = 1'b1;
    for (int a = 0; a < 3; a++) begin
      if (m_ok[a] && m_mag[a] > 13'(mthr)) begin
        m_hit = 1'b1;
      end
      if (!(s_ok[a] && s_mag[a] < 13'(sthr))) begin
        s_hit = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Run counters for the two detectors
  mdc_run_counter #(
    .WIDTH (8)
  ) u_motion_run (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .armed_i   (motion_armed),
    .valid_i   (reg_sample_i.valid),
    .hit_i     (m_hit),
    .target_i  (mcnt),
    .event_o   (m_evt)
  );

  mdc_run_counter #(
    .WIDTH (16)
  ) u_still_run (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .armed_i   (still_armed),
    .valid_i   (reg_sample_i.valid),
    .hit_i     (s_hit),
    .target_i  ({scnt_h, scnt_l}),
    .event_o   (s_evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencing and sticky status; a new event beats a clearing read
  always_comb begin
    next_arm_state   = arm_state;
    next_awake       = awake;
    next_motion_stat = motion_stat && !status_read;
    next_still_stat  = still_stat && !status_read;
    if (!linked) begin
      next_arm_state = MDC_ARM_MOTION;
    end else if (arm_state == MDC_ARM_MOTION && m_evt) begin
      next_arm_state = MDC_ARM_STILL;
    end else if (arm_state == MDC_ARM_STILL && s_evt) begin
      next_arm_state = MDC_ARM_MOTION;
    end
    // Loop mode retires the old event when the other one fires
    if (loop && s_evt) begin
      next_motion_stat = 1'b0;
    end
    if (loop && m_evt) begin
      next_still_stat = 1'b0;
    end
    if (m_evt) begin
      next_motion_stat = 1'b1;
      next_awake       = 1'b1;
    end
    if (s_evt) begin
      next_still_stat = 1'b1;
      next_awake      = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      arm_state   <= MDC_ARM_MOTION;
      motion_stat <= 1'b0;
      still_stat  <= 1'b0;
      awake       <= 1'b0;
    end else begin
      arm_state   <= next_arm_state;
      motion_stat <= next_motion_stat;
      still_stat  <= next_still_stat;
      awake       <= next_awake;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; sleep is only ever allowed under linked sequencing
  assign motion_event_o     = m_evt;
  assign still_event_o      = s_evt;
  assign motion_status_o    = motion_stat;
  assign still_status_o     = still_stat;
  assign awake_o            = awake;
  assign motion_armed_o     = motion_armed;
  assign still_armed_o      = still_armed;
  assign autosleep_permit_o = linked;

endmodule // mdc_top

`default_nettype wire

/* mdc_consts.svh */
// Constants for the motion detect control block: register offsets,
// field positions and reset values.
// Assumes it is included by bare name from the package and design files.
`ifndef MDC_CONSTS_SVH
`define MDC_CONSTS_SVH

// Register offsets
`define MDC_ADDR_STATUS   8'h0B
`define MDC_ADDR_MTHR_L   8'h20
`define MDC_ADDR_MTHR_H   8'h21
`define MDC_ADDR_MCNT     8'h22
`define MDC_ADDR_STHR_L   8'h23
`define MDC_ADDR_STHR_H   8'h24
`define MDC_ADDR_SCNT_L   8'h25
`define MDC_ADDR_SCNT_H   8'h26
`define MDC_ADDR_CTRL     8'h27

// Reset values
`define MDC_CTRL_RESET    8'h00
`define MDC_REG_RESET     8'h00

// Control register field positions
`define MDC_CTRL_MOTION_EN  0
`define MDC_CTRL_MOTION_REF 1
`define MDC_CTRL_STILL_EN   2
`define MDC_CTRL_STILL_REF  3
`define MDC_CTRL_SEQ_LO     4
`define MDC_CTRL_SEQ_HI     5

// Status register field positions
`define MDC_STAT_MOTION   4
`define MDC_STAT_STILL    5
`define MDC_STAT_AWAKE    6

// Valid bits of a threshold high byte
`define MDC_THR_HI_MASK   8'h07

`endif

/* mdc_pkg.sv */
// Types shared by the motion detect control block.
// Assumes mdc_consts.svh is on the include path.
`include "mdc_consts.svh"

package mdc_pkg;

  // One register access from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mdc_reg_req_type;

  // One acceleration sample, three signed 12-bit axes
  typedef struct packed {
    logic               valid;
    logic signed [11:0] x;
    logic signed [11:0] y;
    logic signed [11:0] z;
  } mdc_sample_type;

  // Which detector the linked sequence has armed
  typedef enum logic [0:0] {
    MDC_ARM_MOTION = 1'b0,
    MDC_ARM_STILL  = 1'b1
  } mdc_arm_type;

endpackage

/* mdc_axis_cmp.sv */
// One axis of one detector: reference capture and magnitude.
// Assumes samples arrive on ref_clk_i from same-domain logic.
`timescale 1ns/100ps
`default_nettype none

module mdc_axis_cmp (
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               armed_i,
  input  wire logic               referenced_i,
  input  wire logic               valid_i,
  input  wire logic signed [11:0] sample_i,
  output logic                    ok_o,
  output logic             [12:0] mag_o
);
  import mdc_pkg::*;

  logic signed [11:0] ref_val;
  logic               ref_ok;
  logic signed [11:0] next_ref_val;
  logic               next_ref_ok;
  logic signed [12:0] diff;

  ////////////////////////////////////////////////////////////////////////
  // Reference is caught on the first sample after arming
  always_comb begin
    next_ref_val = ref_val;
    next_ref_ok  = ref_ok;
    if (!armed_i) begin
      next_ref_ok = 1'b0;
    end else if (valid_i && !ref_ok) begin
      next_ref_val = sample_i;
      next_ref_ok  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ref_val <= 12'sh000;
      ref_ok  <= 1'b0;
    end else begin
      ref_val <= next_ref_val;
      ref_ok  <= next_ref_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Thirteen bits so the difference of two extremes cannot wrap
  always_comb begin
    if (referenced_i) begin
      diff = 13'(sample_i) - 13'(ref_val);
    end else begin
      diff = 13'(sample_i);
    end
    mag_o = diff[12] ? 13'(-diff) : 13'(diff);
    ok_o  = !referenced_i || ref_ok; // No verdict until a reference exists
  end

endmodule // mdc_axis_cmp

`default_nettype wire

/* mdc_run_counter.sv */
// Consecutive-sample counter with a one-cycle event output.
// Assumes valid_i and hit_i come from logic on ref_clk_i.
`timescale 1ns/100ps
`default_nettype none

module mdc_run_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             armed_i,
  input  wire logic             valid_i,
  input  wire logic             hit_i,
  input  wire logic [WIDTH-1:0] target_i,
  output logic                  event_o
);
  import mdc_pkg::*;

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_event;
  logic [WIDTH-1:0] goal;

  ////////////////////////////////////////////////////////////////////////
  // A run shorter than the goal restarts on any miss
  always_comb begin
    goal       = (target_i == '0) ? WIDTH'(1) : target_i;
    next_count = count;
    next_event = 1'b0;
    if (!armed_i) begin
      next_count = '0;
    end else if (valid_i) begin
      if (!hit_i) begin
        next_count = '0;
      end else if (WIDTH'(count + 1'b1) >= goal) begin
        next_count = '0;
        next_event = 1'b1;
      end else begin
        next_count = WIDTH'(count + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      count   <= '0;
      event_o <= 1'b0;
    end else begin
      count   <= next_count;
      event_o <= next_event;
    end
  end

endmodule // mdc_run_counter

`default_nettype wire

/* mdc_top_props.sv */
// Checker for mdc_top: register handshake, arming, sequencing and events.
// Assumes it sees only the top ports, attached by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"

module mdc_top_props (
  input wire logic                     ref_clk_i,
  input wire logic                     reset_n_i,
  input wire mdc_pkg::mdc_reg_req_type reg_req_i,
  input wire logic [7:0]               reg_rdata_o,
  input wire logic                     reg_rvalid_o,
  input wire mdc_pkg::mdc_sample_type  reg_sample_i,
  input wire logic                     motion_event_o,
  input wire logic                     still_event_o,
  input wire logic                     motion_status_o,
  input wire logic                     still_status_o,
  input wire logic                     awake_o,
  input wire logic                     motion_armed_o,
  input wire logic                     still_armed_o,
  input wire logic                     autosleep_permit_o
);
  import mdc_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Control writes decoded here so every property sees the same view
  logic ctrl_wr;
  logic link_wr;
  assign ctrl_wr = reg_req_i.wr && (reg_req_i.addr == `MDC_ADDR_CTRL);
  assign link_wr = reg_req_i.wdata[4] && reg_req_i.wdata[2] && reg_req_i.wdata[0];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_read_answer; reg_req_i.rd |=> reg_rvalid_o; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_stray; !reg_req_i.rd |=> !reg_rvalid_o; endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_rdata_hold; !reg_rvalid_o |-> $stable(reg_rdata_o); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // Default sequencing: each enable drives its own detector, no sleep
  property p_default; ctrl_wr && !link_wr |=> !autosleep_permit_o &&
    motion_armed_o == $past(reg_req_i.wdata[0]) && still_armed_o == $past(reg_req_i.wdata[2]);
  endproperty
  a_default: assert property (p_default) else $error("default arming wrong");
  property p_link_enter; ctrl_wr && link_wr && !autosleep_permit_o |=>
    autosleep_permit_o && motion_armed_o && !still_armed_o; endproperty
  a_link_enter: assert property (p_link_enter) else $error("link entry wrong");
  property p_one_armed; autosleep_permit_o |-> motion_armed_o != still_armed_o; endproperty
  a_one_armed: assert property (p_one_armed) else $error("both armed in link");
  property p_swap; autosleep_permit_o && motion_event_o && !ctrl_wr |=> ##1 still_armed_o;
  endproperty
  a_swap: assert property (p_swap) else $error("no swap after motion");
  property p_motion_cause; motion_event_o |-> $past(reg_sample_i.valid && motion_armed_o);
  endproperty
  a_motion_cause: assert property (p_motion_cause) else $error("motion event uncaused");
  property p_still_cause; still_event_o |-> $past(reg_sample_i.valid && still_armed_o);
  endproperty
  a_still_cause: assert property (p_still_cause) else $error("still event uncaused");
  property p_motion_set; motion_event_o |=> motion_status_o && awake_o; endproperty
  a_motion_set: assert property (p_motion_set) else $error("motion status not set");
  property p_ack; reg_req_i.rd && reg_req_i.addr == `MDC_ADDR_STATUS && !motion_event_o
    |=> !motion_status_o; endproperty
  a_ack: assert property (p_ack) else $error("status read did not clear");
endmodule // mdc_top_props

bind mdc_top mdc_top_props u_props (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .reg_sample_i(reg_sample_i),
  .motion_event_o(motion_event_o), .still_event_o(still_event_o),
  .motion_status_o(motion_status_o), .still_status_o(still_status_o), .awake_o(awake_o),
  .motion_armed_o(motion_armed_o), .still_armed_o(still_armed_o),
  .autosleep_permit_o(autosleep_permit_o));
`default_nettype wire

/* mdc_host_model.sv */
// Host side model: register accesses and sample delivery.
// Assumes the bench calls its tasks; all changes land 1 ns after an edge.
`timescale 1ns/100ps
`default_nettype none

module mdc_host_model (
  input  wire logic                   ref_clk_i,
  input  wire logic [7:0]             rdata_i,
  input  wire logic                   rvalid_i,
  output var mdc_pkg::mdc_reg_req_type req_o,
  output var mdc_pkg::mdc_sample_type  sample_o
);
  import mdc_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    req_o = '0;
    sample_o = '0;
  end

  // One access held over one edge; released fields inverted so stale data never looks valid
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    @(posedge ref_clk_i);
    #1;
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk_i);
    #1;
    q = rdata_i;
    v = rvalid_i;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One sample pulse; free-fall users would keep default sequencing here
  task automatic sample(input logic signed [11:0] x, input logic signed [11:0] y,
                        input logic signed [11:0] z);
    @(posedge ref_clk_i);
    #1;
    sample_o = '{valid: 1'b1, x: x, y: y, z: z};
    @(posedge ref_clk_i);
    #1;
    sample_o = '{valid: 1'b0, x: ~x, y: ~y, z: ~z};
  endtask
endmodule // mdc_host_model
`default_nettype wire

/* motion_detect_control_tb.sv */
// Self-checking bench for mdc_top through the host model.
// Assumes the checker is bound to mdc_top by its own file.
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"

module motion_detect_control_tb;
  import mdc_pkg::*;
  logic            ref_clk_i;
  logic            reset_n_i;
  mdc_reg_req_type req;
  mdc_sample_type  smp;
  logic [7:0]      rdata;
  logic            rvalid, mev, sev, mst, sst, awake, marm, sarm, asleep;
  int              n_fail, samples_checked, n_mev, n_sev;
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  mdc_host_model u_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
                         .req_o(req), .sample_o(smp));
  mdc_top u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_sample_i(smp),
    .motion_event_o(mev), .still_event_o(sev), .motion_status_o(mst),
    .still_status_o(sst), .awake_o(awake), .motion_armed_o(marm),
    .still_armed_o(sarm), .autosleep_permit_o(asleep));

  // Event pulses counted at each edge since they stand one cycle only
  always @(posedge ref_clk_i) begin
    if (mev === 1'b1) n_mev++;
    if (sev === 1'b1) n_sev++;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    u_host.access(1'b1, a, d, q, v);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       v;
    u_host.access(1'b0, a, 8'h00, q, v);
    check({7'h00, v}, 8'h01);
    check(q, exp);
  endtask
  // Arming view: motion armed, still armed, sleep permitted
  task automatic flags(input logic [2:0] e);
    check({5'h00, marm, sarm, asleep}, {5'h00, e});
  endtask
  // Let pulses and arm swaps settle before counting
  task automatic evs(input logic [7:0] em, input logic [7:0] es);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(8'(n_mev), em);
    check(8'(n_sev), es);
    n_mev = 0;
    n_sev = 0;
  endtask
  task automatic stop_test();
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the sequence needs about 130 cycles
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    n_fail++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    samples_checked = 0;
    n_mev = 0;
    n_sev = 0;
    reset_n_i = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    #1 reset_n_i = 1'b1;
    rd_chk(`MDC_ADDR_CTRL, 8'h00);
    flags(3'b000);
    wr(`MDC_ADDR_CTRL, 8'hC0);
    rd_chk(`MDC_ADDR_CTRL, 8'hC0);
    rd_chk(8'h30, 8'h00);
    wr(`MDC_ADDR_MTHR_L, 8'h0A);
    wr(`MDC_ADDR_STHR_L, 8'h05);
    // Disabled detectors ignore everything
    wr(`MDC_ADDR_CTRL, 8'h00);
    u_host.sample(12'sd900, 12'sd0, 12'sd0);
    u_host.sample(12'sd0, 12'sd0, 12'sd0);
    evs(8'h00, 8'h00);
    // Absolute activity: equal is no hit, negative axis counts
    wr(`MDC_ADDR_CTRL, 8'h01);
    flags(3'b100);
    u_host.sample(12'sd10, 12'sd0, 12'sd0);
    u_host.sample(12'sd0, 12'sd0, -12'sd20);
    evs(8'h01, 8'h00);
    rd_chk(`MDC_ADDR_STATUS, 8'h50);
    rd_chk(`MDC_ADDR_STATUS, 8'h40);
    // Run of three hits with a break in the middle
    wr(`MDC_ADDR_MCNT, 8'h03);
    for (int i = 0; i < 6; i++) u_host.sample((i == 2) ? 12'sd0 : 12'sd20, 12'sd0, 12'sd0);
    evs(8'h01, 8'h00);
    wr(`MDC_ADDR_MCNT, 8'h00);
    // Inactivity alone, zero count acts as one
    wr(`MDC_ADDR_CTRL, 8'h04);
    flags(3'b010);
    u_host.sample(12'sd4, -12'sd4, 12'sd0);
    u_host.sample(12'sd5, 12'sd0, 12'sd0);
    evs(8'h00, 8'h01);
    rd_chk(`MDC_ADDR_STATUS, 8'h30);
    // Referenced activity: first sample is the reference
    wr(`MDC_ADDR_CTRL, 8'h03);
    u_host.sample(12'sd500, 12'sd0, 12'sd0);
    u_host.sample(12'sd505, 12'sd0, 12'sd0);
    u_host.sample(12'sd515, 12'sd0, 12'sd0);
    evs(8'h01, 8'h00);
    rd_chk(`MDC_ADDR_STATUS, 8'h50);
    // Referenced inactivity: small change from a large reference
    wr(`MDC_ADDR_CTRL, 8'h0C);
    u_host.sample(12'sd500, 12'sd0, 12'sd0);
    u_host.sample(12'sd502, 12'sd0, 12'sd0);
    evs(8'h00, 8'h01);
    rd_chk(`MDC_ADDR_STATUS, 8'h20);
    // Every sequencing code with both enables, then link with one enable
    for (int m = 0; m < 4; m++) begin
      wr(`MDC_ADDR_CTRL, {2'b00, 2'(m), 4'b0101});
      flags(m[0] ? 3'b101 : 3'b110);
    end
    wr(`MDC_ADDR_CTRL, 8'h11);
    flags(3'b100);
    // Linked: alternate arming, host read acknowledges both
    wr(`MDC_ADDR_CTRL, 8'h15);
    flags(3'b101);
    u_host.sample(12'sd20, 12'sd0, 12'sd0);
    evs(8'h01, 8'h00);
    flags(3'b011);
    u_host.sample(12'sd0, 12'sd0, 12'sd0);
    evs(8'h00, 8'h01);
    flags(3'b101);
    rd_chk(`MDC_ADDR_STATUS, 8'h30);
    // Loop: each event acknowledges the other internally
    wr(`MDC_ADDR_CTRL, 8'h35);
    flags(3'b101);
    // Motion, still, motion again with no host read in between
    u_host.sample(12'sd20, 12'sd0, 12'sd0);
    evs(8'h01, 8'h00);
    u_host.sample(12'sd0, 12'sd0, 12'sd0);
    evs(8'h00, 8'h01);
    u_host.sample(12'sd20, 12'sd0, 12'sd0);
    evs(8'h01, 8'h00);
    rd_chk(`MDC_ADDR_STATUS, 8'h50);
    stop_test();
  end
endmodule // motion_detect_control_tb
`default_nettype wire
